// ===== two_wire_slave_receiver.v
// Two-wire slave receiver with a classic Wishbone register slave
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tws_regs.vh"

// What this block does
// - Match bus address against upper seven own-address bits and respond.
// - Own-address bit0 set enables response to general call address zero.
// - Read direction goes transmitter (not built); write direction receives.
// - After own address with write bit, set flag and valid status.
// - Arbitration loss as master then addressed reports 0x68 or 0x78.
// - Clearing ack-enable mid transfer makes next data byte not-acked.
// - Ack-enable zero ignores own address; recognition resumes when set.
// - In deep sleep with ack-enable, recognise address and request wake.
// - After sleep match, hold SCL low until software clears flag.
// - Data register need not hold last bus byte after waking.
// - Own write address acked reports 0x60.
// - Arbitration lost then own write address acked reports 0x68.
// - General call acked reports 0x70.
// - Arbitration lost then general call acked reports 0x78.
// - Data acked under own address reports 0x80, byte in data register.
// - In 0x60 to 0x80, next byte acked only if ack-enable is one.
// - Not-acked byte reports 0x88 (0x98 under general call) then unaddressed slave.
// - Leaving addressed state with start set: unaddressed, start pending.
// - Data acked under general call reports 0x90.
// - Stop or repeated start while addressed reports 0xA0.
module two_wire_slave_receiver (
   // Clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [0:0] sel_i,
   input wire [7:0] dat_i,
   output reg [7:0] dat_o,
   output reg ack_o,
   // System power state, arbitration, start pending, interrupt
   input wire deep_sleep_i,
   input wire arb_lost_i,
   output reg wake_req_o,
   output reg start_pend_o,
   output reg irq_o,
   // Bus pins
   input wire scl_i,
   input wire sda_i,
   output reg scl_oe_o,
   output reg sda_oe_o
);

   // -----------------------------------------------------------------
   // State encoding
   // -----------------------------------------------------------------
   localparam S_IDLE = 5'b00001;
   localparam S_ADDR = 5'b00010;
   localparam S_AACK = 5'b00100;
   localparam S_DATA = 5'b01000;
   localparam S_DACK = 5'b10000;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   reg scl_m_r, scl_s_r, scl_d_r;
   reg sda_m_r, sda_s_r, sda_d_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else if (ce_i) begin
         scl_m_r <= scl_i;
         scl_s_r <= scl_m_r;
         scl_d_r <= scl_s_r;
         sda_m_r <= sda_i;
         sda_s_r <= sda_m_r;
         sda_d_r <= sda_s_r;
      end
   end

   wire scl_rise = scl_s_r & ~scl_d_r;
   wire scl_fall = ~scl_s_r & scl_d_r;
   wire start_det = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
   wire stop_det = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;

   // -----------------------------------------------------------------
   // Registers and state
   // -----------------------------------------------------------------
   reg [7:0] own_address_register;
   reg [7:0] bus_data_register;
   reg [7:0] bus_status_register;
   reg event_flag, acknowledge_enable, start_request, stop_request;
   reg write_collision_flag, interface_enable, event_interrupt_enable;
   reg [4:0] state_r;
   reg [7:0] shift_r;
   reg [3:0] bits_r;
   reg gc_r;
   reg addressed_r;
   reg ack_now_r;
   reg slept_r;

   wire general_call_enable = own_address_register[0];
   // A write lands at the edge where the master samples ack high
   wire wr_stb = cyc_i & stb_i & we_i & sel_i[0] & ack_o;
   wire flag_wr = wr_stb & (adr_i == `ADR_CTRL) & dat_i[`CB_FLAG];
   wire [7:0] ctrl_rd = {event_flag, acknowledge_enable, start_request,
      stop_request, write_collision_flag, interface_enable, 1'b0,
      event_interrupt_enable};

   // Byte complete with address fields
   wire [7:0] rx_byte = shift_r;
   wire own_hit = (rx_byte[7:1] == own_address_register[7:1]);
   wire gc_hit = (rx_byte[7:1] == `GC_ADDR) & general_call_enable;
   wire hold_scl = event_flag & addressed_r;

   // -----------------------------------------------------------------
   // Wishbone slave
   // -----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 8'h00;
      end else if (ce_i) begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         case (adr_i)
            `ADR_DATA: dat_o <= bus_data_register;
            `ADR_OWN: dat_o <= own_address_register;
            `ADR_CTRL: dat_o <= ctrl_rd;
            `ADR_STAT: dat_o <= bus_status_register;
            default: dat_o <= 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Bus engine
   // -----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         own_address_register <= `RST_OWN;
         bus_data_register <= `RST_DATA;
         bus_status_register <= `ST_IDLE;
         event_flag <= 1'b0;
         acknowledge_enable <= 1'b0;
         start_request <= 1'b0;
         stop_request <= 1'b0;
         write_collision_flag <= 1'b0;
         interface_enable <= 1'b0;
         event_interrupt_enable <= 1'b0;
         state_r <= S_IDLE;
         shift_r <= 8'h00;
         bits_r <= 4'h0;
         gc_r <= 1'b0;
         addressed_r <= 1'b0;
         ack_now_r <= 1'b0;
         slept_r <= 1'b0;
         start_pend_o <= 1'b0;
         wake_req_o <= 1'b0;
         irq_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (ce_i) begin
         // Software writes
         if (wr_stb && adr_i == `ADR_OWN)
            own_address_register <= dat_i;
         if (wr_stb && adr_i == `ADR_DATA) begin
            if (event_flag) begin
               bus_data_register <= dat_i;
               write_collision_flag <= 1'b0;
            end else
               write_collision_flag <= 1'b1;
         end
         if (wr_stb && adr_i == `ADR_CTRL) begin
            acknowledge_enable <= dat_i[`CB_ACKEN];
            start_request <= dat_i[`CB_START];
            stop_request <= dat_i[`CB_STOP];
            interface_enable <= dat_i[`CB_EN];
            event_interrupt_enable <= dat_i[`CB_IE];
            if (dat_i[`CB_FLAG]) begin
               event_flag <= 1'b0;
               wake_req_o <= 1'b0;
               slept_r <= 1'b0;
               if (dat_i[`CB_START])
                  start_pend_o <= 1'b1;
            end
         end
         if (start_pend_o && stop_det)
            start_pend_o <= 1'b0;
         irq_o <= event_flag & event_interrupt_enable;
         scl_oe_o <= hold_scl | (slept_r & addressed_r);
         // Serial engine
         if (!interface_enable) begin
            state_r <= S_IDLE;
            addressed_r <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (start_det || stop_det) begin
            if (addressed_r && !event_flag) begin
               bus_status_register <= `ST_STOP;
               event_flag <= 1'b1;
            end
            addressed_r <= 1'b0;
            sda_oe_o <= 1'b0;
            bits_r <= 4'h0;
            state_r <= start_det ? S_ADDR : S_IDLE;
         end else begin
            case (state_r)
               S_IDLE: begin
                  sda_oe_o <= 1'b0;
               end
               S_ADDR, S_DATA: begin
                  if (scl_rise && !hold_scl) begin
                     shift_r <= {shift_r[6:0], sda_s_r};
                     bits_r <= bits_r + 4'h1;
                  end
                  if (scl_fall && bits_r == 4'h8) begin
                     bits_r <= 4'h0;
                     if (state_r == S_ADDR) begin
                        if (acknowledge_enable && !rx_byte[0] &&
                           (own_hit || gc_hit)) begin
                           gc_r <= ~own_hit;
                           sda_oe_o <= 1'b1;
                           slept_r <= deep_sleep_i;
                           wake_req_o <= deep_sleep_i;
                           state_r <= S_AACK;
                        end else begin
                           state_r <= S_IDLE;
                        end
                     end else begin
                        if (!slept_r)
                           bus_data_register <= rx_byte;
                        ack_now_r <= acknowledge_enable;
                        sda_oe_o <= acknowledge_enable;
                        state_r <= S_DACK;
                     end
                  end
               end
               S_AACK: begin
                  if (scl_fall) begin
                     sda_oe_o <= 1'b0;
                     addressed_r <= 1'b1;
                     event_flag <= 1'b1;
                     if (gc_r)
                        bus_status_register <= arb_lost_i ?
                           `ST_ARB_GC : `ST_GC_ACK;
                     else
                        bus_status_register <= arb_lost_i ?
                           `ST_ARB_OWN : `ST_OWN_ACK;
                     state_r <= S_DATA;
                  end
               end
               S_DACK: begin
                  if (scl_fall) begin
                     sda_oe_o <= 1'b0;
                     event_flag <= 1'b1;
                     if (ack_now_r) begin
                        bus_status_register <= gc_r ?
                           `ST_GCD_ACK : `ST_DAT_ACK;
                        state_r <= S_DATA;
                     end else begin
                        bus_status_register <= gc_r ?
                           `ST_GCD_NAK : `ST_DAT_NAK;
                        state_r <= S_IDLE;
                     end
                  end
               end
               default: state_r <= S_IDLE;
            endcase
         end
         // Addressed state ends once a not-ack event is released
         if (flag_wr && (bus_status_register == `ST_DAT_NAK ||
            bus_status_register == `ST_GCD_NAK))
            addressed_r <= 1'b0;
      end
   end

endmodule // two_wire_slave_receiver

// ===== tws_regs.vh
// Register map, field positions and status codes of the two-wire slave
`ifndef TWS_REGS_VH
`define TWS_REGS_VH
// Register byte addresses
`define ADR_DATA 4'h0
`define ADR_OWN 4'h4
`define ADR_CTRL 4'h8
`define ADR_STAT 4'hC
`define ADR_SLEEP 4'h0
// Control register fields
`define CB_FLAG 7
`define CB_ACKEN 6
`define CB_START 5
`define CB_STOP 4
`define CB_WCOL 3
`define CB_EN 2
`define CB_IE 0
// Reset values
`define RST_OWN 8'h00
`define RST_CTRL 8'h00
`define RST_DATA 8'hFF
// Status codes
`define ST_IDLE 8'hF8
`define ST_OWN_ACK 8'h60
`define ST_ARB_OWN 8'h68
`define ST_GC_ACK 8'h70
`define ST_ARB_GC 8'h78
`define ST_DAT_ACK 8'h80
`define ST_DAT_NAK 8'h88
`define ST_GCD_ACK 8'h90
`define ST_GCD_NAK 8'h98
`define ST_STOP 8'hA0
`define GC_ADDR 7'h00
`endif

// ===== tws_checker.sv
// Port checks for the two-wire slave receiver
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_checker (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Register bus
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [7:0] dat_i,
   input wire ack_o,
   // Bus pins, power and interrupt
   input wire scl_i,
   input wire deep_sleep_i,
   input wire scl_oe_o,
   input wire sda_oe_o,
   input wire irq_o,
   input wire wake_req_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire flag_wr;
   assign flag_wr = cyc_i && stb_i && we_i && ack_o && adr_i == `ADR_CTRL
      && dat_i[`CB_FLAG];
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !scl_oe_o
      && !sda_oe_o && !irq_o) else $error("output active after reset");
   a_stretch_hold: assert property (scl_oe_o && !flag_wr &&
      !$past(flag_wr) |=> scl_oe_o)
      else $error("clock stretch ended without flag write");
   a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line changed while clock high");
   a_flag_stretch: assert property ($rose(irq_o) && !scl_i |->
      ##[0:1] scl_oe_o)
      else $error("event without clock stretch");
   a_wake_sleep: assert property ($rose(wake_req_o) |-> deep_sleep_i
      ##[1:16] scl_oe_o) else $error("wake request outside sleep");
   c_stretch: cover property ($rose(scl_oe_o));
   c_wake: cover property ($rose(wake_req_o));
   c_write: cover property (ack_o && we_i);
endmodule // tws_checker

bind two_wire_slave_receiver tws_checker u_chk (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .scl_i(scl_i),
   .deep_sleep_i(deep_sleep_i), .scl_oe_o(scl_oe_o),
   .sda_oe_o(sda_oe_o), .irq_o(irq_o), .wake_req_o(wake_req_o));

// ===== i2c_master_model.sv
// Behavioural two-wire bus master transmitter
`timescale 1ns/1ps
module i2c_master_model (
   // Bus levels
   input wire scl_i,
   input wire sda_i,
   // Pull-downs, high pulls the line low
   output reg scl_lo_o,
   output reg sda_lo_o
);
   integer w;
   reg s;
   initial begin
      scl_lo_o = 1'b0;
      sda_lo_o = 1'b0;
   end
   task put_bit(input reg b);
      begin
         #200 sda_lo_o = ~b;
         #200 scl_lo_o = 1'b0;
         w = 0;
         // Slave may stretch the low phase
         while (scl_i !== 1'b1 && w < 20000) begin
            #100 w = w + 1;
         end
         #400 s = sda_i;
         scl_lo_o = 1'b1;
      end
   endtask
   task start;
      begin
         // Keep bus edges off the system clock edges
         #25 sda_lo_o = 1'b1;
         #400 scl_lo_o = 1'b1;
      end
   endtask
   task stop;
      begin
         #225 sda_lo_o = 1'b1;
         #200 scl_lo_o = 1'b0;
         #400 sda_lo_o = 1'b0;
         #400;
      end
   endtask
   task send_byte(input reg [7:0] d, output reg acked);
      integer k;
      begin
         #25;
         for (k = 7; k >= 0; k = k - 1)
            put_bit(d[k]);
         put_bit(1'b1);
         acked = ~s;
      end
   endtask
endmodule // i2c_master_model

// ===== tb_top.sv
// Self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
`include "tws_regs.vh"
module tb_top;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg cyc = 1'b0;
   reg stb = 1'b0;
   reg we = 1'b0;
   reg [3:0] adr = 4'h0;
   reg [7:0] dat = 8'h00;
   reg sleep = 1'b0;
   reg arb = 1'b0;
   wire [7:0] dat_o;
   wire ack_o, wake_o, pend_o, irq_o, scl_oe, sda_oe, scl_lo, sda_lo;
   wire scl = ~(scl_oe | scl_lo);
   wire sda = ~(sda_oe | sda_lo);
   integer fails = 0;
   integer n_tests = 0;
   integer i;
   reg [7:0] q;
   reg a;
   two_wire_slave_receiver u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(1'b1), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
      .deep_sleep_i(sleep), .arb_lost_i(arb), .wake_req_o(wake_o),
      .start_pend_o(pend_o), .irq_o(irq_o), .scl_i(scl), .sda_i(sda),
      .scl_oe_o(scl_oe), .sda_oe_o(sda_oe));
   i2c_master_model u_mst (.scl_i(scl), .sda_i(sda), .scl_lo_o(scl_lo),
      .sda_lo_o(sda_lo));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task print_verdict;
      begin
         if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input string nm, input reg [7:0] e, input reg [7:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails = fails + 1;
         end
      end
   endtask
   task wb(input reg w, input reg [3:0] ad, input reg [7:0] d);
      integer n;
      begin
         @(posedge clk_i);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= ad;
         dat <= d;
         n = 0;
         @(posedge clk_i);
         while (ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n == 50)
            fails = fails + 1;
         q = dat_o;
         cyc <= 1'b0;
         stb <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task rchk(input reg [3:0] ad, input reg [7:0] e, input string nm);
      begin
         wb(1'b0, ad, 8'h00);
         chk(nm, e, q);
      end
   endtask
   task xfer(input reg [7:0] d, input reg e);
      begin
         u_mst.send_byte(d, a);
         repeat (5) @(posedge clk_i);
         chk("ack", {7'h00, e}, {7'h00, a});
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(`ADR_STAT, `ST_IDLE, "stat");
      rchk(`ADR_DATA, `RST_DATA, "data");
      rchk(`ADR_CTRL, `RST_CTRL, "ctrl");
      rchk(4'h1, 8'h00, "unmapped");
      wb(1'b1, `ADR_OWN, 8'hA5);
      rchk(`ADR_OWN, 8'hA5, "own");
      wb(1'b1, `ADR_CTRL, 8'h45);
      // Own, lost-own, general call, lost-general-call
      for (i = 0; i < 4; i = i + 1) begin
         arb <= i[0];
         u_mst.start;
         xfer(i[1] ? 8'h00 : 8'hA4, 1'b1);
         rchk(`ADR_STAT, 8'h60 + {i[1:0], 3'h0}, "addr");
         chk("stretch", 8'h01, {7'h00, scl_oe});
         chk("irq", 8'h01, {7'h00, irq_o});
         wb(1'b1, `ADR_CTRL, 8'hC5);
         @(posedge clk_i);
         chk("release", 8'h00, {7'h00, scl_oe});
         xfer(8'h3C, 1'b1);
         rchk(`ADR_STAT, i[1] ? 8'h90 : 8'h80, "dstat");
         rchk(`ADR_DATA, 8'h3C, "data");
         wb(1'b1, `ADR_CTRL, 8'hC5);
         u_mst.stop;
         repeat (5) @(posedge clk_i);
         rchk(`ADR_STAT, `ST_STOP, "stop");
         wb(1'b1, `ADR_CTRL, 8'hC5);
      end
      arb <= 1'b0;
      u_mst.start;
      xfer(8'hA4, 1'b1);
      wb(1'b1, `ADR_CTRL, 8'h85);
      xfer(8'h55, 1'b0);
      rchk(`ADR_STAT, `ST_DAT_NAK, "nak");
      wb(1'b1, `ADR_CTRL, 8'hA4);
      chk("pend", 8'h01, {7'h00, pend_o});
      u_mst.stop;
      u_mst.start;
      xfer(8'hA4, 1'b0);
      u_mst.stop;
      wb(1'b1, `ADR_OWN, 8'hA4);
      wb(1'b1, `ADR_CTRL, 8'h44);
      // Read direction, foreign address, disabled general call
      for (i = 0; i < 3; i = i + 1) begin
         u_mst.start;
         xfer(i == 0 ? 8'hA5 : (i == 1 ? 8'hA6 : 8'h00), 1'b0);
         u_mst.stop;
      end
      sleep <= 1'b1;
      u_mst.start;
      xfer(8'hA4, 1'b1);
      chk("wake", 8'h01, {7'h00, wake_o});
      chk("hold", 8'h01, {7'h00, scl_oe});
      sleep <= 1'b0;
      wb(1'b1, `ADR_CTRL, 8'hC4);
      chk("wake clr", 8'h00, {7'h00, wake_o});
      u_mst.stop;
      print_verdict;
   end
   initial begin
      #2000000;
      fails = fails + 1;
      print_verdict;
   end
endmodule // tb_top
